//--- verilog/glc_gpio_ctrl.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module glc_gpio_ctrl (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [glc_pkg::GLC_AW-1:0]    paddr,
	input  wire logic [glc_pkg::GLC_DW-1:0]    pwdata,
	output logic      [glc_pkg::GLC_DW-1:0]    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// Pads
	input  wire logic [glc_pkg::GLC_LINES-1:0] line_in,
	output logic      [glc_pkg::GLC_LINES-1:0] line_out,
	output logic      [glc_pkg::GLC_LINES-1:0] line_oe_n,
	output logic      [glc_pkg::GLC_LINES-1:0] pullup_en,
	// Peripheral functions
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_a_out,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_a_oe,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_b_out,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_b_oe,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_c_out,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_c_oe,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_d_out,
	input  wire logic [glc_pkg::GLC_LINES-1:0] periph_d_oe,
	output logic      [glc_pkg::GLC_LINES-1:0] periph_in,
	// Interrupt
	output logic                                irq
);
	import glc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [GLC_LINES-1:0] drive_value_ff;
	logic [GLC_LINES-1:0] irq_mask_ff;
	logic [GLC_LINES-1:0] irq_status_ff;
	logic [GLC_LINES-1:0] od_state_ff;
	logic [GLC_LINES-1:0] pullup_dis_ff;
	logic [GLC_LINES-1:0] fsel_low_ff;
	logic [GLC_LINES-1:0] fsel_high_ff;
	logic                 wprot_ff;
	logic [GLC_LINES-1:0] ctrl_own_ff;
	logic [GLC_LINES-1:0] out_en_ff;
	logic [GLC_LINES-1:0] line_out_ff;
	logic [GLC_LINES-1:0] line_oe_n_ff;
	logic [GLC_DW-1:0]    prdata_ff;

	logic [GLC_LINES-1:0] pin_level;
	logic [GLC_LINES-1:0] pin_change;
	logic [GLC_LINES-1:0] nxt_irq_status;
	logic [GLC_LINES-1:0] status_clr;
	logic [GLC_LINES-1:0] nxt_line_out;
	logic [GLC_LINES-1:0] nxt_line_oe_n;
	logic [GLC_DW-1:0]    rd_mux;
	logic                 addr_hit;
	logic                 setup_rd;
	logic                 access;
	logic                 wr_en;
	logic                 cfg_wr_en;
	logic                 status_rd;
	logic                 wr_drive;
	logic                 wr_own;
	logic                 wr_out_en;
	logic                 wr_wprot;
	logic                 wr_irq_en;
	logic                 wr_irq_dis;
	logic                 wr_status;
	logic                 wr_od_en;
	logic                 wr_od_dis;
	logic                 wr_pu_off;
	logic                 wr_pu_on;
	logic                 wr_fsel_low;
	logic                 wr_fsel_high;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation and change detection

	glc_line_sync u_sync (
		.clk     (clk),
		.rst     (rst),
		.line_in (line_in),
		.level   (pin_level),
		.change  (pin_change)
	);

	assign periph_in = pin_level;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	// Zero wait states: the access phase always completes in its first cycle
	assign access    = psel & penable;
	assign setup_rd  = psel & ~penable & ~pwrite;
	assign wr_en     = access & pwrite & addr_hit;
	assign cfg_wr_en = wr_en & ~wprot_ff;
	assign status_rd = access & ~pwrite & (paddr == GLC_ADDR_IRQ_STATUS);

	// One strobe per register keeps the decode in one place
	assign wr_drive     = wr_en & (paddr == GLC_ADDR_DRIVE_VALUE);
	assign wr_own       = wr_en & (paddr == GLC_ADDR_CTRL_OWN);
	assign wr_out_en    = wr_en & (paddr == GLC_ADDR_OUT_EN);
	assign wr_wprot     = wr_en & (paddr == GLC_ADDR_WPROT);
	assign wr_irq_en    = wr_en & (paddr == GLC_ADDR_IRQ_ENABLE);
	assign wr_irq_dis   = wr_en & (paddr == GLC_ADDR_IRQ_DISABLE);
	assign wr_status    = wr_en & (paddr == GLC_ADDR_IRQ_STATUS);
	assign wr_od_en     = cfg_wr_en & (paddr == GLC_ADDR_OD_ENABLE);
	assign wr_od_dis    = cfg_wr_en & (paddr == GLC_ADDR_OD_DISABLE);
	assign wr_pu_off    = cfg_wr_en & (paddr == GLC_ADDR_PULLUP_OFF);
	assign wr_pu_on     = cfg_wr_en & (paddr == GLC_ADDR_PULLUP_ON);
	assign wr_fsel_low  = cfg_wr_en & (paddr == GLC_ADDR_FSEL_LOW);
	assign wr_fsel_high = cfg_wr_en & (paddr == GLC_ADDR_FSEL_HIGH);

	always_comb begin
		addr_hit = 1'b1;
		rd_mux   = '0;
		case (paddr)
			GLC_ADDR_DRIVE_VALUE: rd_mux = drive_value_ff;
			GLC_ADDR_PIN_LEVEL: rd_mux = pin_level;
			GLC_ADDR_IRQ_ENABLE: rd_mux = '0;
			GLC_ADDR_IRQ_DISABLE: rd_mux = '0;
			GLC_ADDR_IRQ_MASK: rd_mux = irq_mask_ff;
			GLC_ADDR_IRQ_STATUS: rd_mux = irq_status_ff;
			GLC_ADDR_OD_ENABLE: rd_mux = '0;
			GLC_ADDR_OD_DISABLE: rd_mux = '0;
			GLC_ADDR_OD_STATE: rd_mux = od_state_ff;
			GLC_ADDR_PULLUP_OFF: rd_mux = '0;
			GLC_ADDR_PULLUP_ON: rd_mux = '0;
			GLC_ADDR_PULLUP_STATE: rd_mux = pullup_dis_ff;
			GLC_ADDR_FSEL_LOW: rd_mux = fsel_low_ff;
			GLC_ADDR_FSEL_HIGH: rd_mux = fsel_high_ff;
			GLC_ADDR_WPROT: rd_mux = {{(GLC_DW-1){1'b0}}, wprot_ff};
			GLC_ADDR_CTRL_OWN: rd_mux = ctrl_own_ff;
			GLC_ADDR_OUT_EN: rd_mux = out_en_ff;
			default: begin
				addr_hit = 1'b0;
				rd_mux   = '0;
			end
		endcase
	end

	// Read data is captured in the setup phase so it leaves a flip-flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_ff <= '0;
		end else if (setup_rd) begin
			prdata_ff <= rd_mux;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = access;
	assign pslverr = access & ~addr_hit;

	////////////////////////////////////////////////////////////////////////////////
	// Drive value and controller ownership

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_value_ff <= GLC_RST_DRIVE_VALUE;
		end else if (wr_drive) begin
			drive_value_ff <= pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_own_ff <= GLC_RST_CTRL_OWN;
		end else if (wr_own) begin
			ctrl_own_ff <= pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_en_ff <= GLC_RST_OUT_EN;
		end else if (wr_out_en) begin
			out_en_ff <= pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wprot_ff <= GLC_RST_WPROT;
		end else if (wr_wprot) begin
			wprot_ff <= pwdata[GLC_WPROT_ON_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Change interrupt mask and status

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask_ff <= GLC_RST_IRQ_MASK;
		end else if (wr_irq_en) begin
			irq_mask_ff <= irq_mask_ff | pwdata;
		end else if (wr_irq_dis) begin
			irq_mask_ff <= irq_mask_ff & ~pwdata;
		end
	end

	// A read clears only what it reported, so a change after setup survives
	always_comb begin
		status_clr = '0;
		if (status_rd) begin
			status_clr = prdata_ff;
		end else if (wr_status) begin
			status_clr = pwdata;
		end
	end

	// New changes win over a clear in the same cycle
	assign nxt_irq_status = (irq_status_ff & ~status_clr) | pin_change;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status_ff <= GLC_RST_IRQ_STATUS;
		end else begin
			irq_status_ff <= nxt_irq_status;
		end
	end

	assign irq = |(irq_status_ff & irq_mask_ff);

	////////////////////////////////////////////////////////////////////////////////
	// Protected configuration

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			od_state_ff <= GLC_RST_OD_STATE;
		end else if (wr_od_en) begin
			od_state_ff <= od_state_ff | pwdata;
		end else if (wr_od_dis) begin
			od_state_ff <= od_state_ff & ~pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pullup_dis_ff <= GLC_RST_PULLUP_DIS;
		end else if (wr_pu_off) begin
			pullup_dis_ff <= pullup_dis_ff | pwdata;
		end else if (wr_pu_on) begin
			pullup_dis_ff <= pullup_dis_ff & ~pwdata;
		end
	end

	assign pullup_en = ~pullup_dis_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fsel_low_ff <= GLC_RST_FSEL;
		end else if (wr_fsel_low) begin
			fsel_low_ff <= pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fsel_high_ff <= GLC_RST_FSEL;
		end else if (wr_fsel_high) begin
			fsel_high_ff <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-line output mux

	genvar gi;
	generate
		for (gi = 0; gi < GLC_LINES; gi++) begin : g_line
			glc_func_t func;
			logic      val;
			logic      en;

			assign func = glc_func_t'({fsel_high_ff[gi], fsel_low_ff[gi]});

			always_comb begin
				val = 1'b0;
				en  = 1'b0;
				if (ctrl_own_ff[gi]) begin
					val = drive_value_ff[gi];
					en  = out_en_ff[gi];
				end else begin
					unique case (func)
						GLC_FUNC_A: begin
							val = periph_a_out[gi];
							en  = periph_a_oe[gi];
						end
						GLC_FUNC_B: begin
							val = periph_b_out[gi];
							en  = periph_b_oe[gi];
						end
						GLC_FUNC_C: begin
							val = periph_c_out[gi];
							en  = periph_c_oe[gi];
						end
						GLC_FUNC_D: begin
							val = periph_d_out[gi];
							en  = periph_d_oe[gi];
						end
					endcase
				end
			end

			// Open-drain releases the pad for a high, letting the pull-up win
			assign nxt_line_out[gi]  = val;
			assign nxt_line_oe_n[gi] = ~(en & ~(od_state_ff[gi] & val));
		end
	endgenerate

	// Registered pads cost one cycle but keep the pins glitch-free
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_out_ff  <= '0;
			line_oe_n_ff <= '1;
		end else begin
			line_out_ff  <= nxt_line_out;
			line_oe_n_ff <= nxt_line_oe_n;
		end
	end

	assign line_out  = line_out_ff;
	assign line_oe_n = line_oe_n_ff;

endmodule

//--- verilog/glc_pkg.sv
package glc_pkg;

	localparam int          GLC_LINES = 32;
	localparam int          GLC_AW    = 32;
	localparam int          GLC_DW    = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [31:0] GLC_ADDR_DRIVE_VALUE  = 32'hfffff438;
	localparam logic [31:0] GLC_ADDR_PIN_LEVEL    = 32'hfffff43c;
	localparam logic [31:0] GLC_ADDR_IRQ_ENABLE   = 32'hfffff440;
	localparam logic [31:0] GLC_ADDR_IRQ_DISABLE  = 32'hfffff444;
	localparam logic [31:0] GLC_ADDR_IRQ_MASK     = 32'hfffff448;
	localparam logic [31:0] GLC_ADDR_IRQ_STATUS   = 32'hfffff44c;
	localparam logic [31:0] GLC_ADDR_OD_ENABLE    = 32'hfffff450;
	localparam logic [31:0] GLC_ADDR_OD_DISABLE   = 32'hfffff454;
	localparam logic [31:0] GLC_ADDR_OD_STATE     = 32'hfffff458;
	localparam logic [31:0] GLC_ADDR_PULLUP_OFF   = 32'hfffff460;
	localparam logic [31:0] GLC_ADDR_PULLUP_ON    = 32'hfffff464;
	localparam logic [31:0] GLC_ADDR_PULLUP_STATE = 32'hfffff468;
	localparam logic [31:0] GLC_ADDR_FSEL_LOW     = 32'hfffff46c;
	localparam logic [31:0] GLC_ADDR_FSEL_HIGH    = 32'hfffff470;
	localparam logic [31:0] GLC_ADDR_WPROT        = 32'hfffff4e4;
	localparam logic [31:0] GLC_ADDR_CTRL_OWN     = 32'hfffff4f0;
	localparam logic [31:0] GLC_ADDR_OUT_EN       = 32'hfffff4f4;

	////////////////////////////////////////////////////////////////////////////////
	// Fields
	localparam int          GLC_WPROT_ON_BIT = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] GLC_RST_DRIVE_VALUE = 32'h0000_0000;
	localparam logic [31:0] GLC_RST_IRQ_MASK    = 32'h0000_0000;
	localparam logic [31:0] GLC_RST_IRQ_STATUS  = 32'h0000_0000;
	localparam logic [31:0] GLC_RST_OD_STATE    = 32'h0000_0000;
	localparam logic [31:0] GLC_RST_PULLUP_DIS  = 32'h0000_0000;
	localparam logic [31:0] GLC_RST_FSEL        = 32'h0000_0000;
	localparam logic        GLC_RST_WPROT       = 1'h0;
	localparam logic [31:0] GLC_RST_CTRL_OWN    = 32'hffff_ffff;
	localparam logic [31:0] GLC_RST_OUT_EN      = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: cycles after reset before change detection is armed
	localparam logic [2:0]  GLC_SETTLE_CYCLES = 3'h4;

	typedef enum logic [1:0] {
		GLC_FUNC_A = 2'b00,
		GLC_FUNC_B = 2'b01,
		GLC_FUNC_C = 2'b10,
		GLC_FUNC_D = 2'b11
	} glc_func_t;

endpackage

//--- verilog/glc_line_sync.sv
`timescale 1ns/1ps

module glc_line_sync (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// Raw pin levels
	input  wire logic [glc_pkg::GLC_LINES-1:0] line_in,
	// Settled level and change flags
	output logic      [glc_pkg::GLC_LINES-1:0] level,
	output logic      [glc_pkg::GLC_LINES-1:0] change
);
	import glc_pkg::*;

	logic [GLC_LINES-1:0] meta_ff;
	logic [GLC_LINES-1:0] sync2_ff;
	logic [GLC_LINES-1:0] sync3_ff;
	logic [GLC_LINES-1:0] level_ff;
	logic [GLC_LINES-1:0] prev_ff;
	logic [GLC_LINES-1:0] change_ff;
	logic [2:0]           settle_ff;
	logic [GLC_LINES-1:0] nxt_level;
	logic                 armed;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff  <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			meta_ff  <= line_in;
			sync2_ff <= meta_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// A level counts only once the second and third stages agree
	assign nxt_level = (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & level_ff);
	assign armed     = (settle_ff == GLC_SETTLE_CYCLES);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_ff <= '0;
		end else if (!armed) begin
			settle_ff <= settle_ff + 3'h1;
		end
	end

	// Held off after reset so a pin that idles high gives no false change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_ff  <= '0;
			prev_ff   <= '0;
			change_ff <= '0;
		end else begin
			level_ff  <= nxt_level;
			// Until armed, history tracks the incoming level so both agree at arming
			prev_ff   <= armed ? level_ff : nxt_level;
			change_ff <= armed ? (level_ff ^ prev_ff) : '0;
		end
	end

	assign level  = level_ff;
	assign change = change_ff;

endmodule

//--- dv/glc_sva.sv
`timescale 1ns/1ps
module glc_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Pads and interrupt
	input wire logic [31:0] line_in,
	input wire logic [31:0] line_out,
	input wire logic [31:0] line_oe_n,
	input wire logic [31:0] pullup_en,
	input wire logic        irq
);
	import glc_pkg::*;
	logic        wr;
	logic        wp_ff;
	logic [31:0] msk_ff;
	logic [31:0] od_ff;
	logic [31:0] od_dly_ff;
	logic [31:0] in_ff;
	logic [3:0]  stab_ff;
	assign wr = psel && penable && pwrite;
	// Shadow state, so no check needs to look inside
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_ff <= 1'h0;
			msk_ff <= 32'h0;
			od_ff <= 32'h0;
			od_dly_ff <= 32'h0;
			in_ff <= 32'h0;
			stab_ff <= 4'h0;
		end else begin
			in_ff <= line_in;
			od_dly_ff <= od_ff;
			stab_ff <= (line_in != in_ff) ? 4'h0 : stab_ff + {3'h0, stab_ff != 4'hf};
			if (wr && paddr == GLC_ADDR_WPROT)
				wp_ff <= pwdata[GLC_WPROT_ON_BIT];
			if (wr && paddr == GLC_ADDR_IRQ_ENABLE)
				msk_ff <= msk_ff | pwdata;
			if (wr && paddr == GLC_ADDR_IRQ_DISABLE)
				msk_ff <= msk_ff & ~pwdata;
			if (wr && !wp_ff && paddr == GLC_ADDR_OD_ENABLE)
				od_ff <= od_ff | pwdata;
			if (wr && !wp_ff && paddr == GLC_ADDR_OD_DISABLE)
				od_ff <= od_ff & ~pwdata;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_cfg(logic [31:0] a);
		wr && !wp_ff && paddr == a;
	endsequence
	sequence s_rd(logic [31:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	chk_pullup_on: assert property (s_cfg(GLC_ADDR_PULLUP_ON) |=>
		(pullup_en & $past(pwdata)) == $past(pwdata)) else $error("pull-up not on");
	chk_pullup_off: assert property (s_cfg(GLC_ADDR_PULLUP_OFF) |=>
		(pullup_en & $past(pwdata)) == 32'h0) else $error("pull-up not off");
	chk_protect_pull: assert property (wr && wp_ff && (paddr == GLC_ADDR_PULLUP_ON
		|| paddr == GLC_ADDR_PULLUP_OFF) |=> $stable(pullup_en)) else $error("protected write took");
	// Drive path lags the register by one edge, hence the delayed copy
	chk_od_low_only: assert property ((od_dly_ff & ~line_oe_n & line_out) == 32'h0)
		else $error("open-drain line driven high");
	chk_pin_read: assert property (s_rd(GLC_ADDR_PIN_LEVEL) && stab_ff > 4'h7
		|-> prdata == line_in) else $error("pin level readback wrong");
	chk_mask_read: assert property (s_rd(GLC_ADDR_IRQ_MASK) |-> prdata == msk_ff)
		else $error("mask readback wrong");
	chk_od_read: assert property (s_rd(GLC_ADDR_OD_STATE) |-> prdata == od_ff)
		else $error("open-drain state wrong");
	chk_irq_masked: assert property (msk_ff == 32'h0 |-> !irq)
		else $error("irq with all lines masked");
	chk_irq_sticky: assert property ($fell(irq) |-> $past(psel && penable
		&& (paddr == GLC_ADDR_IRQ_STATUS || paddr == GLC_ADDR_IRQ_DISABLE)))
		else $error("irq dropped without clear");
endmodule
bind glc_gpio_ctrl glc_sva i_glc_sva (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .line_in, .line_out, .line_oe_n, .pullup_en, .irq);

//--- dv/glc_pad_model.sv
`timescale 1ns/1ps
module glc_pad_model (
	// Clock
	input  wire logic        clk,
	// Controller pad side
	input  wire logic [31:0] line_out,
	input  wire logic [31:0] line_oe_n,
	input  wire logic [31:0] pullup_en,
	output logic      [31:0] line_in,
	// Board drivers
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	// Peripheral functions
	output logic      [31:0] periph_a_out,
	output logic      [31:0] periph_a_oe,
	output logic      [31:0] periph_b_out,
	output logic      [31:0] periph_b_oe,
	output logic      [31:0] periph_c_out,
	output logic      [31:0] periph_c_oe,
	output logic      [31:0] periph_d_out,
	output logic      [31:0] periph_d_oe
);
	logic [31:0] last_ff;
	logic [31:0] drv;
	assign drv = ~line_oe_n;
	// Undriven, unpulled lines toggle so a stale value never passes
	assign line_in = (drv & line_out) | (~drv & ext_en & ext_val)
		| (~drv & ~ext_en & (pullup_en | ~last_ff));
	always_ff @(posedge clk)
		last_ff <= line_in;
	////////////////////////////////////////
	// One distinct bit pair per function in byte 1
	assign periph_a_out = 32'h0000_1100;
	assign periph_b_out = 32'h0000_2200;
	assign periph_c_out = 32'h0000_4400;
	assign periph_d_out = 32'h0000_8800;
	assign periph_a_oe = 32'hffff_ffff;
	assign periph_b_oe = 32'hffff_ffff;
	assign periph_c_oe = 32'hffff_ffff;
	assign periph_d_oe = 32'hffff_ffff;
endmodule

//--- dv/glc_gpio_ctrl_tb.sv
`timescale 1ns/1ps
module glc_gpio_ctrl_tb;
	import glc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] ext_en = 32'h0;
	logic [31:0] ext_val = 32'h0;
	logic [31:0] prdata, line_in, line_out, line_oe_n, pullup_en, rdata, periph_in;
	logic [31:0] periph_a_out, periph_a_oe, periph_b_out, periph_b_oe;
	logic [31:0] periph_c_out, periph_c_oe, periph_d_out, periph_d_oe;
	logic        pready, pslverr, irq, rerr;
	int          mismatches = 0;
	int          samples_checked = 0;
	always #5 clk = ~clk;
	glc_gpio_ctrl i_glc_gpio_ctrl (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .line_in, .line_out, .line_oe_n, .pullup_en,
		.periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe, .periph_c_out,
		.periph_c_oe, .periph_d_out, .periph_d_oe, .periph_in, .irq);
	glc_pad_model i_glc_pad_model (.clk, .line_out, .line_oe_n, .pullup_en, .line_in,
		.ext_en, .ext_val, .periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe,
		.periph_c_out, .periph_c_oe, .periph_d_out, .periph_d_oe);
	////////////////////////////////////////
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: no pready", $time);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		rdc(GLC_ADDR_IRQ_MASK, GLC_RST_IRQ_MASK);
		rdc(GLC_ADDR_OD_STATE, GLC_RST_OD_STATE);
		rdc(GLC_ADDR_PULLUP_STATE, 32'h0);
		rdc(GLC_ADDR_FSEL_HIGH, GLC_RST_FSEL);
		rdc(32'hfffff45c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
	endtask
	task automatic t_irq;
		wr(GLC_ADDR_IRQ_ENABLE, 32'h8);
		wr(GLC_ADDR_IRQ_ENABLE, 32'h0);
		rdc(GLC_ADDR_IRQ_MASK, 32'h8);
		rdc(GLC_ADDR_IRQ_STATUS, 32'h0);
		ext_en <= 32'h8;
		repeat (10) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rdc(GLC_ADDR_PIN_LEVEL, 32'hffff_fff7);
		chk(periph_in, 32'hffff_fff7);
		rdc(GLC_ADDR_IRQ_STATUS, 32'h8);
		// Status clears on the read's own edge; look once it has settled
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(GLC_ADDR_IRQ_DISABLE, 32'h8);
		rdc(GLC_ADDR_IRQ_MASK, 32'h0);
		ext_en <= 32'h0;
		repeat (10) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_drive;
		wr(GLC_ADDR_DRIVE_VALUE, 32'h5);
		wr(GLC_ADDR_OUT_EN, 32'hf);
		rdc(GLC_ADDR_DRIVE_VALUE, 32'h5);
		chk(line_out & 32'hf, 32'h5);
		chk(line_oe_n & 32'hf, 32'h0);
		wr(GLC_ADDR_OD_ENABLE, 32'h3);
		rdc(GLC_ADDR_OD_STATE, 32'h3);
		chk(line_oe_n & 32'hf, 32'h1);
		wr(GLC_ADDR_OD_DISABLE, 32'h1);
		rdc(GLC_ADDR_OD_STATE, 32'h2);
		chk(line_oe_n & 32'hf, 32'h0);
	endtask
	task automatic t_pull;
		wr(GLC_ADDR_PULLUP_OFF, 32'h30);
		rdc(GLC_ADDR_PULLUP_STATE, 32'h30);
		chk(pullup_en, 32'hffff_ffcf);
		wr(GLC_ADDR_PULLUP_ON, 32'h10);
		rdc(GLC_ADDR_PULLUP_STATE, 32'h20);
	endtask
	task automatic t_protect;
		wr(GLC_ADDR_WPROT, 32'h1);
		wr(GLC_ADDR_OD_ENABLE, 32'hf0);
		wr(GLC_ADDR_PULLUP_OFF, 32'hf00);
		wr(GLC_ADDR_FSEL_LOW, 32'hff);
		wr(GLC_ADDR_FSEL_HIGH, 32'hff);
		rdc(GLC_ADDR_OD_STATE, 32'h2);
		rdc(GLC_ADDR_PULLUP_STATE, 32'h20);
		rdc(GLC_ADDR_FSEL_LOW, 32'h0);
		rdc(GLC_ADDR_FSEL_HIGH, 32'h0);
		wr(GLC_ADDR_WPROT, 32'h0);
	endtask
	task automatic t_func;
		chk(line_oe_n & 32'hff00, 32'hff00);
		wr(GLC_ADDR_CTRL_OWN, 32'hffff_00ff);
		for (int f = 0; f < 4; f++) begin
			wr(GLC_ADDR_FSEL_LOW, f[0] ? 32'hff00 : 32'h0);
			wr(GLC_ADDR_FSEL_HIGH, f[1] ? 32'hff00 : 32'h0);
			rdc(GLC_ADDR_FSEL_LOW, f[0] ? 32'hff00 : 32'h0);
			chk(line_out & 32'hff00, 32'h1100 << f);
			chk(line_oe_n & 32'hff00, 32'h0);
		end
	endtask
	////////////////////////////////////////
	task automatic close_out;
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_irq;
		t_drive;
		t_pull;
		t_protect;
		t_func;
		close_out;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#300us;
		mismatches++;
		close_out;
	end
endmodule
